// ===== inc/upper_dma_defs.vh
// Register offsets, field positions and codes for the upper DMA mask and mode block
`ifndef UPPER_DMA_DEFS_VH
`define UPPER_DMA_DEFS_VH

// ---------------------------------------------------------------
// I/O addresses
// ---------------------------------------------------------------
`define MASK_WRITE_ADDR      16'h00d4
`define MODE_WRITE_ADDR      16'h00d6

// ---------------------------------------------------------------
// Mask register fields
// ---------------------------------------------------------------
`define MASK_VALUE_BIT       2
`define MASK_SEL_LSB         0

// ---------------------------------------------------------------
// Mode register fields
// ---------------------------------------------------------------
`define MODE_XFER_LSB        6
`define MODE_DIR_BIT         5
`define MODE_AUTO_INIT_CONTROL_BIT       4
`define MODE_OP_LSB          2
`define MODE_SEL_LSB         0

// ---------------------------------------------------------------
// Transfer mode and operation codes
// ---------------------------------------------------------------
`define XFER_DEMAND          2'h0
`define XFER_SINGLE          2'h1
`define XFER_BLOCK           2'h2
`define XFER_CASCADE         2'h3
`define OP_VERIFY            2'h0
`define OP_WRITE             2'h1
`define OP_READ              2'h2

// ---------------------------------------------------------------
// Reset values (documented undefined; chosen as all masked, zeros)
// ---------------------------------------------------------------
`define MASK_RESET           4'hf
`define MODE_RESET           8'h00
`define CHAN_BIT_RESET       4'h0

`endif

// ===== rtl/upper_dma_mask_mode.v
// Mask and mode state for DMA channels 4 to 7 on the direct-mapped I/O bus
//
// How it works
// - Mask write sets or clears chosen mask
// - Mask selector picks channels 4 to 7
// - No auto-init: mask sets at terminal count
// - Auto-init: mask stays clear at terminal count
// - Set mask blocks that channel's request
// - Three registers share one mask set
// - Mode field: demand, single, block
// - Code 11 is cascade, stored for any channel
// - Direction bit: 0 increments, 1 decrements
// - Bit 4 enables auto-init for selected channel
// - Mode fields apply to selected channel only
// - Mode selector picks channels 4 to 7
// - Operation: verify, write, read, reserved
// - Auto-init pulses reload_out at terminal count
`include "upper_dma_defs.vh"
`default_nettype none

module upper_dma_mask_mode (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        srst,
   // Direct-mapped I/O write port
   input  wire        io_wr,
   input  wire [15:0] io_addr,
   input  wire [7:0]  io_wdata,
   // Mask-clear-all and general mask writes from sibling registers
   input  wire        clear_all_wr,
   input  wire        general_mask_wr,
   input  wire [3:0]  general_mask_data,
   // Terminal count pulses from the transfer engine, one per channel
   input  wire [3:0]  end_of_count,
   // Peripheral requests
   input  wire [3:0]  dreq_in,
   // Gated requests and per-channel configuration to the engine
   output reg  [3:0]  dreq_gated,
   output reg  [3:0]  mask_out,
   output reg  [7:0]  xfer_mode_out,
   output reg  [7:0]  op_out,
   output reg  [3:0]  addr_dec_out,
   output reg  [3:0]  auto_init_out,
   output reg  [3:0]  reload_out
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg  [3:0] mask_reg;        // Shared mask set
   reg  [3:0] mask_next;
   reg  [7:0] xfer_reg;        // Two bits per channel
   reg  [7:0] op_reg;          // Two bits per channel
   reg  [3:0] dir_reg;         // Address direction per channel
   reg  [3:0] auto_init_control_reg;       // Auto-init per channel
   reg  [7:0] xfer_next;
   reg  [7:0] op_next;
   reg  [3:0] dir_next;
   reg  [3:0] auto_init_control_next;

   // Write strobes, registers are write-only; no read path
   wire mask_wr = io_wr && (io_addr == `MASK_WRITE_ADDR);
   wire mode_wr = io_wr && (io_addr == `MODE_WRITE_ADDR);

   // One-hot channel decode of a two-bit selector
   function [3:0] chan_onehot;
      input [1:0] sel;
      begin
         chan_onehot = 4'h1 << sel;
      end
   endfunction

   wire [1:0] mask_sel = io_wdata[`MASK_SEL_LSB +: 2];
   wire [1:0] mode_sel = io_wdata[`MODE_SEL_LSB +: 2];
   wire [3:0] mask_hot = chan_onehot(mask_sel);
   wire [3:0] mode_hot = chan_onehot(mode_sel);

   // ------------------------------------------------------------
   // Next mask value
   // ------------------------------------------------------------
   integer i;
   always @* begin
      mask_next = mask_reg;
      // Terminal count sets mask only without auto-init
      for (i = 0; i < 4; i = i + 1) begin
         if (end_of_count[i] && !auto_init_control_reg[i]) begin
            mask_next[i] = 1'b1;
         end
      end
      // Software paths, all on the same bits; terminal set wins
      if (clear_all_wr) begin
         mask_next = mask_next & ~(~end_of_count | auto_init_control_reg);
      end else if (general_mask_wr) begin
         mask_next = general_mask_data |
                     (end_of_count & ~auto_init_control_reg);
      end else if (mask_wr) begin
         if (io_wdata[`MASK_VALUE_BIT]) begin
            mask_next = mask_next | mask_hot;
         end else begin
            // Clear only selected channel, others untouched
            mask_next = mask_next &
               ~(mask_hot & ~(end_of_count & ~auto_init_control_reg));
         end
      end
   end

   // ------------------------------------------------------------
   // Next mode values, selected channel only
   // ------------------------------------------------------------
   integer k;
   always @* begin
      xfer_next  = xfer_reg;
      op_next    = op_reg;
      dir_next   = dir_reg;
      auto_init_control_next = auto_init_control_reg;
      for (k = 0; k < 4; k = k + 1) begin
         if (mode_wr && mode_hot[k]) begin
            // Demand, single, block or cascade code
            xfer_next[2*k +: 2] = io_wdata[`MODE_XFER_LSB +: 2];
            // Verify, write, read; reserved stored as written
            op_next[2*k +: 2]   = io_wdata[`MODE_OP_LSB +: 2];
            dir_next[k]   = io_wdata[`MODE_DIR_BIT];
            auto_init_control_next[k] = io_wdata[`MODE_AUTO_INIT_CONTROL_BIT];
         end
      end
   end

   // ------------------------------------------------------------
   // Registers and outputs
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (srst) begin
         mask_reg      <= `MASK_RESET;
         xfer_reg      <= `MODE_RESET;
         op_reg        <= `MODE_RESET;
         dir_reg       <= `CHAN_BIT_RESET;
         auto_init_control_reg     <= `CHAN_BIT_RESET;
         dreq_gated    <= `CHAN_BIT_RESET;
         mask_out      <= `MASK_RESET;
         xfer_mode_out <= `MODE_RESET;
         op_out        <= `MODE_RESET;
         addr_dec_out  <= `CHAN_BIT_RESET;
         auto_init_out <= `CHAN_BIT_RESET;
         reload_out    <= `CHAN_BIT_RESET;
      end else begin
         mask_reg      <= mask_next;
         xfer_reg      <= xfer_next;
         op_reg        <= op_next;
         dir_reg       <= dir_next;
         auto_init_control_reg     <= auto_init_control_next;
         // Masked channels never pass a request
         dreq_gated    <= dreq_in & ~mask_next;
         mask_out      <= mask_next;
         xfer_mode_out <= xfer_next;
         op_out        <= op_next;
         addr_dec_out  <= dir_next;
         auto_init_out <= auto_init_control_next;
         // Reload strobe when count ends with auto-init on
         reload_out    <= end_of_count & auto_init_control_reg;
      end
   end

endmodule

`default_nettype wire

// ===== verif/upper_dma_mask_mode_checker.sv
// Assertion checker for the upper channel mask and mode block
`default_nettype none
module upper_dma_mask_mode_checker (
   // All ports of the block
   input wire logic        clk_sys, srst, io_wr,
   input wire logic        clear_all_wr, general_mask_wr,
   input wire logic [15:0] io_addr,
   input wire logic [7:0]  io_wdata, xfer_mode_out, op_out,
   input wire logic [3:0]  general_mask_data, end_of_count, dreq_in, dreq_gated,
   input wire logic [3:0]  mask_out, addr_dec_out, auto_init_out, reload_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Plain mask write with no competing mask source
   wire mwr = io_wr && io_addr == 16'h00d4 && !clear_all_wr
      && !general_mask_wr && end_of_count == 4'h0;
   wire [3:0] keep = end_of_count & auto_init_out & ~mask_out;
   mask_write_a:
      assert property (mwr |=> mask_out[$past(io_wdata[1:0])]
         == $past(io_wdata[2])) else $error("mask write lost");
   eoc_mask_a:
      assert property ((end_of_count & ~auto_init_out) != 4'h0 |=>
         (mask_out & $past(end_of_count & ~auto_init_out))
         == $past(end_of_count & ~auto_init_out)) else $error("no eoc mask");
   auto_init_control_keep_a:
      assert property (keep != 4'h0 && !io_wr && !general_mask_wr |=>
         (mask_out & $past(keep)) == 4'h0) else $error("auto-init masked");
   req_gate_a:
      assert property (1 |=> dreq_gated == ($past(dreq_in) & ~mask_out))
         else $error("request gating wrong");
   clear_all_a:
      assert property (clear_all_wr && end_of_count == 4'h0 |=>
         mask_out == 4'h0) else $error("clear all failed");
   gen_mask_a:
      assert property (general_mask_wr && !clear_all_wr && end_of_count == 0
         |=> mask_out == $past(general_mask_data)) else $error("general bad");
   mode_fields_a:
      assert property (io_wr && io_addr == 16'h00d6 |=>
         {xfer_mode_out[$past(io_wdata[1:0])*2 +: 2],
         addr_dec_out[$past(io_wdata[1:0])],
         auto_init_out[$past(io_wdata[1:0])],
         op_out[$past(io_wdata[1:0])*2 +: 2]} == $past(io_wdata[7:2]))
         else $error("mode fields wrong");
   reload_a:
      assert property (1 |=> reload_out == $past(end_of_count & auto_init_out))
         else $error("reload pulse wrong");
endmodule
bind upper_dma_mask_mode upper_dma_mask_mode_checker chk_u (.*);
`default_nettype wire

// ===== verif/dreq_source_model.sv
// Peripheral request source beside the upper DMA channels
`default_nettype none
module dreq_source_model (
   input  wire logic       clk_sys,
   input  wire logic [3:0] want,
   output var  logic [3:0] dreq_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial dreq_in = 4'h0;
   // Level requests, moved at the falling edge only
   always @(negedge clk_sys) dreq_in <= want;
endmodule
`default_nettype wire

// ===== verif/upper_dma_mask_mode_tb.sv
// Self-checking testbench for the upper channel mask and mode block
`include "upper_dma_defs.vh"
`default_nettype none
module upper_dma_mask_mode_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, srst = 1, io_wr = 0, clear_all_wr = 0, general_mask_wr = 0;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0]  io_wdata = 8'h00, xm = 8'h00, op = 8'h00, d;
   logic [3:0]  general_mask_data = 4'h0, end_of_count = 4'h0, want = 4'h0;
   logic [3:0]  ad = 4'h0, ai = 4'h0, m = 4'hf;
   wire  [3:0]  dreq_in, dreq_gated, mask_out, addr_dec_out, auto_init_out;
   wire  [3:0]  reload_out;
   wire  [7:0]  xfer_mode_out, op_out;
   int bad_count = 0, samples_checked = 0;
   always #25 clk_sys = ~clk_sys;
   upper_dma_mask_mode dut_u (.*);
   dreq_source_model src_u (.*);
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One byte write, held across one rising edge
   task automatic wr(logic [15:0] a, logic [7:0] v);
      @(negedge clk_sys);
      {io_wr, io_addr, io_wdata} = {1'b1, a, v};
      @(negedge clk_sys);
      io_wr = 0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge clk_sys);
      srst = 0;
      chk("mask_rst", 8'h0f, mask_out);
      for (int c = 0; c < 4; c++) begin
         d = {2'(c + 3), c[0], c[1], 2'(c), 2'(c)};
         wr(`MODE_WRITE_ADDR, d);
         xm[2*c +: 2] = d[7:6];
         op[2*c +: 2] = d[3:2];
         ad[c] = d[5];
         ai[c] = d[4];
         chk("xfer", xm, xfer_mode_out);
         chk("op", op, op_out);
         chk("dir_ai", {ad, ai},
             {addr_dec_out, auto_init_out});
      end
      $display("modes done");
      for (int c = 0; c < 4; c++) begin
         wr(`MASK_WRITE_ADDR, 8'(c));
         m[c] = 1'b0;
         chk("mask", m, mask_out);
      end
      want = 4'hf;
      repeat (2) @(negedge clk_sys);
      chk("req_open", 8'h0f, dreq_gated);
      want = 4'hd;
      wr(`MASK_WRITE_ADDR, 8'h05);
      want = 4'hf;
      repeat (2) @(negedge clk_sys);
      chk("req_mask", 8'h0d, dreq_gated);
      wr(`MASK_WRITE_ADDR, 8'h01);
      @(negedge clk_sys);
      chk("req_again", 8'h0f, dreq_gated);
      $display("masks done");
      end_of_count = 4'hf;
      @(negedge clk_sys);
      end_of_count = 4'h0;
      chk("eoc_mask", 8'h03, mask_out);
      chk("reload", 8'h0c, reload_out);
      @(negedge clk_sys);
      chk("reload_end", 8'h00, reload_out);
      $display("count end done");
      clear_all_wr = 1;
      @(negedge clk_sys);
      {clear_all_wr, general_mask_wr, general_mask_data} = {2'b01, 4'h9};
      chk("clr_all", 8'h00, mask_out);
      @(negedge clk_sys);
      general_mask_wr = 0;
      chk("general", 8'h09, mask_out);
      wr(16'h00d2, 8'h00);
      chk("unmapped", 8'h09, mask_out);
      $display("shared masks done");
      tally_and_finish;
   end
   initial begin
      repeat (400) @(posedge clk_sys);
      bad_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
